/* bench/tb.sv */
/*
 * self-checking bench for the capture controller.
 * assumes one 125 MHz clock and a sample on every cycle.
 */
module tb;
  timeunit 1ns;
  timeprecision 1ps;
  import twc_pkg::*;

  logic clk_i, rst_i, reg_wr_i, reg_rd_i, smp_valid_i, ext_trig_i;
  logic [ADR_W-1:0] reg_addr_i;
  logic [DAT_W-1:0] reg_wdata_i, reg_rdata_o, d;
  logic [SMP_W-1:0] smp_i, cap_data_o, cap_first, cap_prev, fsmp;
  logic cap_valid_o, armed_o, done_o, irq_o, dir;
  logic [63:0] tf [4];
  logic [2:0] code;
  int scnt, cyc, ncap, cap_bad, len, fail_count, checks_done;

  twc_top uut (.clk_i(clk_i), .rst_i(rst_i), .reg_addr_i(reg_addr_i),
    .reg_wdata_i(reg_wdata_i), .reg_wr_i(reg_wr_i), .reg_rd_i(reg_rd_i),
    .reg_rdata_o(reg_rdata_o), .smp_valid_i(smp_valid_i), .smp_i(smp_i),
    .ext_trig_i(ext_trig_i), .cap_valid_o(cap_valid_o),
    .cap_data_o(cap_data_o), .armed_o(armed_o), .done_o(done_o),
    .irq_o(irq_o));

  twc_host h (.clk_i(clk_i), .reg_rdata_i(reg_rdata_o),
    .reg_addr_o(reg_addr_i), .reg_wdata_o(reg_wdata_i),
    .reg_wr_o(reg_wr_i), .reg_rd_o(reg_rd_i));

  initial begin
    clk_i = 1'b0;
    forever #4 clk_i = ~clk_i;
  end

  // sample ramp and capture monitor
  always @(posedge clk_i) begin
    cyc <= cyc + 1;
    scnt <= scnt + 1;
    smp_i <= dir ? 16'(-scnt) : 16'(scnt);
    if (cap_valid_o) begin
      ncap <= ncap + 1;
      if (ncap == 0)
        cap_first <= cap_data_o;
      if (ncap % len != 0 && cap_data_o !== cap_prev + 16'h0001)
        cap_bad <= cap_bad + 1;
      cap_prev <= cap_data_o;
    end
  end

  task automatic chk(string nm, logic [63:0] e, logic [63:0] g);
    checks_done++;
    if (g !== e) begin
      fail_count++;
      $display("ERROR %s expected %0h seen %0h", nm, e, g);
    end
  endtask

  task automatic end_of_test();
    if (fail_count == 0 && checks_done > 0)
      $display("NO MISMATCHES");
    else
      $display("MISMATCHES SEEN");
    $finish;
  endtask

  task automatic wait_arm(int n);
    for (int i = 0; i < n; i++) begin
      @(negedge clk_i);
      if (armed_o === 1'b1 || done_o === 1'b1)
        return;
    end
    chk("wait", 1, 0);
    end_of_test();
  endtask

  task automatic irq_chk(logic [ADR_W-1:0] a, logic [2:0] v, logic e);
    h.wr(a, 32'(v));
    @(posedge clk_i);
    @(negedge clk_i);
    chk("irq", 64'(e), 64'(irq_o));
  endtask

  task automatic run(int pts, int b);
    logic [DAT_W-1:0] lo, hi;
    h.wr(OFS_CTRL, 32'h0000_0002);
    h.wr(OFS_LENGTH, 32'(len));
    h.wr(OFS_POINTS, 32'(pts));
    h.wr(OFS_BEGIN, 32'(b));
    h.wr(OFS_CFG, 32'h0000_0000);
    h.wr(OFS_IRQ_CLR, 32'h0000_0007);
    h.wr(OFS_IRQ_EN, 32'h0000_0001);
    h.rd(OFS_TOTAL, d);
    chk("total", 64'(len * pts), 64'(d));
    ncap = 0;
    cap_bad = 0;
    h.wr(OFS_CTRL, 32'h0000_0001);
    if (b < 0) begin
      h.rd(OFS_STATE, d);
      chk("arming", 64'h001, 64'(d[8:0]));
    end
    for (int p = 0; p < pts; p++) begin
      wait_arm(1000);
      chk("armed", 64'h3, 64'({armed_o, ~done_o}));
      h.rd(OFS_STATE, d);
      chk("st_armed", 64'h102, 64'(d[9:0]));
      repeat ($urandom % 20) @(posedge clk_i);
      fsmp = smp_i;
      h.wr(OFS_CTRL, 32'h0000_0004);
      tf[p] = 64'(cyc);
      h.rd(OFS_STATE, d);
      chk("st_trig", 64'h003, 64'(d[9:0]));
    end
    h.poll(2000, code);
    chk("poll", 64'h4, 64'(code));
    if (code != 3'h4)
      end_of_test();
    chk("done", 64'h1, 64'(done_o));
    chk("ncap", 64'(len * pts), 64'(ncap));
    chk("contig", 0, 64'(cap_bad));
    if (pts == 1)
      chk("begin", 64'(1), 64'(($signed(cap_first) - ($signed(fsmp) + b))
        inside {[-3:3]}));
    h.rd(OFS_PROG, d);
    chk("prog", 64'(len * pts), 64'(d));
    h.rd(OFS_PTPROG, d);
    chk("ptprog", 64'(pts), 64'(d));
    h.rd(OFS_STATE, d);
    chk("flags", 64'({pts > 1, 1'b1, 1'b0}), 64'(d[10:8]));
    for (int i = 0; i < pts - 1; i++) begin
      h.wr(OFS_PTSEL, 32'(i));
      h.rd(OFS_PTLO, lo);
      h.rd(OFS_PTHI, hi);
      chk("ofs", tf[i+1] - tf[0], {hi, lo});
    end
    chk("irq_done", 64'h1, 64'(irq_o));
    irq_chk(OFS_IRQ_EN, 3'h0, 1'b0);
    irq_chk(OFS_IRQ_EN, 3'h1, 1'b1);
    irq_chk(OFS_IRQ_CLR, 3'h7, 1'b0);
  endtask

  initial begin
    rst_i = 1'b1;
    smp_valid_i = 1'b0;
    ext_trig_i = 1'b0;
    smp_i = '0;
    dir = 1'b0;
    {scnt, cyc, ncap, cap_bad, fail_count, checks_done} = '0;
    len = 1;
    void'($urandom(13603));
    repeat (16) @(posedge clk_i);
    rst_i <= 1'b0;
    smp_valid_i <= 1'b1;
    h.rd(OFS_STATE, d);
    chk("rst_state", 64'h0, 64'(d[10:0]));
    h.rd(OFS_TOTAL, d);
    chk("rst_total", 64'h1, 64'(d));
    h.rd(8'hFC, d);
    chk("unmapped", 64'h0, 64'(d));
    h.wr(OFS_TOTAL, 32'h0000_0055);
    h.rd(OFS_TOTAL, d);
    chk("ro_total", 64'h1, 64'(d));
    len = 1 + $urandom % 8;
    run(2 + $urandom % 3, 0);
    len = 1 + $urandom % 8;
    run(1, -1 - int'($urandom % 200));
    h.wr(OFS_CTRL, 32'h0000_0001);
    h.rd(OFS_STATE, d);
    chk("rearm", 64'h1, 64'(d[2:0]));
    wait_arm(400);
    h.wr(OFS_CTRL, 32'h0000_0002);
    h.rd(OFS_STATE, d);
    chk("clear", 64'h0, 64'(d[10:0]));
    h.wr(OFS_CTRL, 32'h0000_0004);
    h.rd(OFS_STATE, d);
    chk("frc_idle", 64'h3, 64'(d[2:0]));
    h.wr(OFS_BEGIN, 32'h0000_0000);
    h.wr(OFS_POINTS, 32'h0000_0001);
    for (int k = 0; k < 4; k++) begin
      h.wr(OFS_CTRL, 32'h0000_0002);
      dir <= k[1];
      repeat (4) @(posedge clk_i);
      h.wr(OFS_CFG, 32'h0000_0002 | 32'(k[0]) << CFG_FALL);
      h.wr(OFS_LEVEL, k[1] ? 32'(-(scnt + 60)) : 32'(scnt + 60));
      h.wr(OFS_CTRL, 32'h0000_0001);
      repeat (150) @(posedge clk_i);
      h.rd(OFS_TRGCNT, d);
      chk("trgcnt", 64'(k[0] == k[1]), 64'(d));
      h.rd(OFS_STATE, d);
      chk("edge", k[0] == k[1] ? 64'h3 : 64'h2, 64'(d[2:0]));
    end
    // external pin, rising then falling edge
    for (int k = 0; k < 2; k++) begin
      h.wr(OFS_CTRL, 32'h0000_0002);
      h.wr(OFS_CFG, 32'h0000_0001 | 32'(k) << CFG_FALL);
      h.wr(OFS_CTRL, 32'h0000_0001);
      wait_arm(10);
      @(posedge clk_i);
      ext_trig_i <= !k[0];
      repeat (8) @(posedge clk_i);
      h.rd(OFS_TRGCNT, d);
      chk("ext_cnt", 64'h1, 64'(d));
      h.rd(OFS_STATE, d);
      chk("ext_edge", 64'h3, 64'(d[2:0]));
    end
    end_of_test();
  end
endmodule

/* bench/twc_host.sv */
/*
 * host model: register port master and state polling.
 * assumes the capture block answers reads one cycle after the strobe.
 */
module twc_host (
  input  wire logic                      clk_i,
  input  wire logic [twc_pkg::DAT_W-1:0] reg_rdata_i,
  output logic [twc_pkg::ADR_W-1:0]      reg_addr_o,
  output logic [twc_pkg::DAT_W-1:0]      reg_wdata_o,
  output logic                           reg_wr_o,
  output logic                           reg_rd_o
);
  timeunit 1ns;
  timeprecision 1ps;
  import twc_pkg::*;

  initial begin
    reg_addr_o = '0;
    reg_wdata_o = '0;
    reg_wr_o = 1'b0;
    reg_rd_o = 1'b0;
  end

  task automatic wr(input logic [ADR_W-1:0] a, input logic [DAT_W-1:0] d);
    @(posedge clk_i);
    reg_addr_o <= a;
    reg_wdata_o <= d;
    reg_wr_o <= 1'b1;
    @(posedge clk_i);
    reg_wr_o <= 1'b0;
  endtask

  task automatic rd(input logic [ADR_W-1:0] a, output logic [DAT_W-1:0] d);
    @(posedge clk_i);
    reg_addr_o <= a;
    reg_rd_o <= 1'b1;
    @(posedge clk_i);
    reg_rd_o <= 1'b0;
    @(negedge clk_i);
    d = reg_rdata_i;
  endtask

  // stop at done, idle or after tmo further reads
  task automatic poll(input int unsigned tmo, output logic [2:0] code);
    logic [DAT_W-1:0] d;
    int unsigned n;
    n = 0;
    rd(OFS_STATE, d);
    while (d[2:0] != 3'h4 && d[2:0] != 3'h0 && n < tmo) begin
      n++;
      rd(OFS_STATE, d);
    end
    code = d[2:0];
  endtask
endmodule

/* common/twc_pkg.sv */
/*
 * shared constants for the triggered waveform capture block:
 * widths, register offsets, field positions, reset values, states.
 * assumes a 32-bit plain register port with byte offsets.
 */
package twc_pkg;
  localparam int SMP_W   = 16;
  localparam int LEN_W   = 16;
  localparam int PTS_W   = 5;
  localparam int TOT_W   = 21;
  localparam int IDX_W   = 64;
  localparam int ADR_W   = 8;
  localparam int DAT_W   = 32;
  localparam int MAX_PTS = 16;
  localparam int OFS_AW  = 4;
  localparam int HIST    = 256;
  localparam int HIST_AW = 8;
  localparam int EV_W    = 3;

  localparam logic [ADR_W-1:0] OFS_CTRL    = 8'h00;
  localparam logic [ADR_W-1:0] OFS_CFG     = 8'h04;
  localparam logic [ADR_W-1:0] OFS_BEGIN   = 8'h08;
  localparam logic [ADR_W-1:0] OFS_LENGTH  = 8'h0C;
  localparam logic [ADR_W-1:0] OFS_POINTS  = 8'h10;
  localparam logic [ADR_W-1:0] OFS_LEVEL   = 8'h14;
  localparam logic [ADR_W-1:0] OFS_STATE   = 8'h18;
  localparam logic [ADR_W-1:0] OFS_TOTAL   = 8'h1C;
  localparam logic [ADR_W-1:0] OFS_PROG    = 8'h20;
  localparam logic [ADR_W-1:0] OFS_PTPROG  = 8'h24;
  localparam logic [ADR_W-1:0] OFS_TRGCNT  = 8'h28;
  localparam logic [ADR_W-1:0] OFS_PTSEL   = 8'h2C;
  localparam logic [ADR_W-1:0] OFS_PTLO    = 8'h30;
  localparam logic [ADR_W-1:0] OFS_PTHI    = 8'h34;
  localparam logic [ADR_W-1:0] OFS_IRQ_ST  = 8'h38;
  localparam logic [ADR_W-1:0] OFS_IRQ_CLR = 8'h3C;
  localparam logic [ADR_W-1:0] OFS_IRQ_EN  = 8'h40;

  localparam int CTL_ARM   = 0;
  localparam int CTL_CLR   = 1;
  localparam int CTL_FRC   = 2;
  localparam int CFG_FALL  = 4;
  localparam int ST_ARMBIT = 8;
  localparam int ST_DONBIT = 9;
  localparam int ST_OFSBIT = 10;
  localparam int EV_DONE   = 0;
  localparam int EV_TRIG   = 1;
  localparam int EV_ARMED  = 2;

  localparam logic [1:0]       SRC_SOFT = 2'h0;
  localparam logic [1:0]       SRC_EXT  = 2'h1;
  localparam logic [1:0]       SRC_LVL  = 2'h2;
  localparam logic [LEN_W-1:0] LEN_RST  = 16'h0001;
  localparam logic [PTS_W-1:0] PTS_RST  = 5'h01;
  localparam logic [8:0]       HIST_CNT = 9'h100;

  typedef enum logic [4:0] {
    ST_IDLE   = 5'b00001,
    ST_ARMING = 5'b00010,
    ST_ARMED  = 5'b00100,
    ST_TRIG   = 5'b01000,
    ST_DONE   = 5'b10000
  } twc_state_e;
endpackage

/* core/twc_front.sv */
/*
 * trigger detection and pre-trigger history ring.
 * assumes samples on clk_i; the external trigger pin is asynchronous.
 */
module twc_front (
  input  wire logic                      clk_i,
  input  wire logic                      rst_i,
  input  wire logic                      smp_valid_i,
  input  wire logic [twc_pkg::SMP_W-1:0] smp_i,
  input  wire logic                      ext_trig_i,
  input  wire logic [1:0]                src_i,
  input  wire logic                      falling_i,
  input  wire logic [twc_pkg::SMP_W-1:0] level_i,
  output logic                           hit_o,
  output logic                           dly_valid_o,
  output logic [twc_pkg::SMP_W-1:0]      dly_data_o
);
  import twc_pkg::*;

  logic [1:0]         sync_r;
  logic               prev_r;
  logic               above_r;
  logic               filled_r;
  logic [HIST_AW-1:0] wp_r;
  logic [SMP_W-1:0]   ring [HIST];

  wire now_above = $signed(smp_i) >= $signed(level_i);
  wire lvl_hit   = smp_valid_i && (now_above != above_r)
                   && (now_above != falling_i);
  wire ext_hit   = (sync_r[1] != prev_r)
                   && (sync_r[1] != falling_i);
  wire hit_nxt   = (src_i == SRC_EXT) ? ext_hit :
                   (src_i == SRC_LVL) ? lvl_hit : 1'b0;

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      sync_r  <= 2'h0;
      prev_r  <= 1'b0;
      above_r <= 1'b0;
      hit_o   <= 1'b0;
    end else begin
      sync_r  <= {sync_r[0], ext_trig_i};
      prev_r  <= sync_r[1];
      hit_o   <= hit_nxt;
      if (smp_valid_i) begin
        above_r <= now_above;
      end
    end
  end

  // history ring delays the stream by HIST samples
  always_ff @(posedge clk_i) begin
    if (smp_valid_i) begin
      ring[wp_r] <= smp_i;
      dly_data_o <= ring[wp_r];
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      wp_r        <= '0;
      filled_r    <= 1'b0;
      dly_valid_o <= 1'b0;
    end else begin
      dly_valid_o <= smp_valid_i && filled_r;
      if (smp_valid_i) begin
        wp_r     <= wp_r + 1'b1;
        filled_r <= filled_r || (&wp_r);
      end
    end
  end
endmodule

/* core/twc_ofs_mem.sv */
/*
 * storage for trigger point offsets, one 64-bit word per point after the first.
 * assumes one writer; read is combinational from a stable index.
 */
module twc_ofs_mem (
  input  wire logic                       clk_i,
  input  wire logic                       we_i,
  input  wire logic [twc_pkg::OFS_AW-1:0] wa_i,
  input  wire logic [twc_pkg::IDX_W-1:0]  wd_i,
  input  wire logic [twc_pkg::OFS_AW-1:0] ra_i,
  output logic [twc_pkg::IDX_W-1:0]       rd_o
);
  import twc_pkg::*;

  logic [IDX_W-1:0] mem [MAX_PTS];

  always_ff @(posedge clk_i) begin
    if (we_i) begin
      mem[wa_i] <= wd_i;
    end
  end

  assign rd_o = mem[ra_i];
endmodule

/* core/twc_top.sv */
/*
 * triggered waveform capture controller: state machine, segment
 * capture, progress counters, point offsets, registers, interrupt.
 * assumes a plain register port and a sample stream on clk_i.
 */
// Operation
// - capture length samples from begin offset
// - total length is length times points
// - done only after points accepted triggers
// - sample progress equals total at done
// - point progress equals points at done
// - store 64-bit offsets from first point
// - offsets invalid unless done and points above one
// - state reported as five codes
// - arm request goes to arming from anywhere
// - clear request goes to idle from anywhere
// - force request enters triggered regardless
// - armed flag high only in armed
// - done flag high only in done
// - begin offset signed, negative means before
// - edge select picks rising or falling
// - count detected trigger events
module twc_top (
  input  wire logic                      clk_i,
  input  wire logic                      rst_i,
  input  wire logic [twc_pkg::ADR_W-1:0] reg_addr_i,
  input  wire logic [twc_pkg::DAT_W-1:0] reg_wdata_i,
  input  wire logic                      reg_wr_i,
  input  wire logic                      reg_rd_i,
  output logic [twc_pkg::DAT_W-1:0]      reg_rdata_o,
  input  wire logic                      smp_valid_i,
  input  wire logic [twc_pkg::SMP_W-1:0] smp_i,
  input  wire logic                      ext_trig_i,
  output logic                           cap_valid_o,
  output logic [twc_pkg::SMP_W-1:0]      cap_data_o,
  output logic                           armed_o,
  output logic                           done_o,
  output logic                           irq_o
);
  import twc_pkg::*;

  twc_state_e       state_r;
  twc_state_e       state_nxt;
  logic [1:0]       src_r;
  logic             fall_r;
  logic [DAT_W-1:0] beg_r;
  logic [LEN_W-1:0] len_r;
  logic [PTS_W-1:0] pts_r;
  logic [SMP_W-1:0] lvl_r;
  logic [OFS_AW-1:0] sel_r;
  logic [EV_W-1:0]  irq_st_r;
  logic [EV_W-1:0]  irq_st_nxt;
  logic [EV_W-1:0]  irq_en_r;
  logic [IDX_W-1:0] smp_cnt_r;
  logic [IDX_W-1:0] dly_idx_r;
  logic [IDX_W-1:0] start_r;
  logic [IDX_W-1:0] first_r;
  logic [LEN_W-1:0] seg_cnt_r;
  logic             cap_on_r;
  logic [TOT_W-1:0] prog_r;
  logic [PTS_W-1:0] pt_prog_r;
  logic [PTS_W-1:0] acc_cnt_r;
  logic [DAT_W-1:0] trg_cnt_r;
  logic [8:0]       hist_cnt_r;
  logic             hit;
  logic             dly_valid;
  logic [SMP_W-1:0] dly_data;
  logic [IDX_W-1:0] ofs_rd;
  logic [DAT_W-1:0] rd_mux;

  // register write decode
  wire wr_ctrl = reg_wr_i && (reg_addr_i == OFS_CTRL);
  wire clr_req = wr_ctrl && reg_wdata_i[CTL_CLR];
  wire arm_req = wr_ctrl && reg_wdata_i[CTL_ARM] && !clr_req;
  wire frc_req = wr_ctrl && reg_wdata_i[CTL_FRC] && !clr_req && !arm_req;
  wire wr_cfg  = reg_wr_i && (reg_addr_i == OFS_CFG);
  wire wr_beg  = reg_wr_i && (reg_addr_i == OFS_BEGIN);
  wire wr_len  = reg_wr_i && (reg_addr_i == OFS_LENGTH);
  wire wr_pts  = reg_wr_i && (reg_addr_i == OFS_POINTS);
  wire wr_lvl  = reg_wr_i && (reg_addr_i == OFS_LEVEL);
  wire wr_sel  = reg_wr_i && (reg_addr_i == OFS_PTSEL);
  wire wr_iclr = reg_wr_i && (reg_addr_i == OFS_IRQ_CLR);
  wire wr_ien  = reg_wr_i && (reg_addr_i == OFS_IRQ_EN);

  // sequencing terms
  wire in_idle  = (state_r == ST_IDLE);
  wire in_armg  = (state_r == ST_ARMING);
  wire in_armed = (state_r == ST_ARMED);
  wire in_trig  = (state_r == ST_TRIG);
  wire in_done  = (state_r == ST_DONE);
  wire hist_ok  = !beg_r[DAT_W-1] || (hist_cnt_r == HIST_CNT);
  wire restart  = arm_req || (frc_req && (in_idle || in_done));
  wire accept   = !clr_req && !arm_req
                  && ((in_armed && hit) || (frc_req && !in_trig));
  wire [PTS_W-1:0] acc_base = restart ? '0 : acc_cnt_r;
  wire [IDX_W-1:0] trig_idx = smp_cnt_r - 64'h0000_0000_0000_0001;
  wire [IDX_W-1:0] beg_ext  = {{(IDX_W-DAT_W){beg_r[DAT_W-1]}}, beg_r};
  wire cap_go   = in_trig && dly_valid
                  && (cap_on_r || (dly_idx_r >= start_r));
  wire seg_end  = cap_go && (seg_cnt_r == len_r - LEN_RST);
  wire last_pt  = (pt_prog_r == pts_r - PTS_RST);
  wire ofs_we   = accept && (acc_base != '0) && (acc_base < PTS_W'(MAX_PTS));
  wire [OFS_AW-1:0] ofs_wa = OFS_AW'(acc_base - PTS_RST);
  wire [IDX_W-1:0] ofs_wd  = trig_idx - first_r;
  wire [TOT_W-1:0] total   = len_r * pts_r;
  wire [2:0] st_code = {state_r[4], state_r[3] | state_r[2],
                        state_r[3] | state_r[1]};
  wire ofs_ok = in_done && (pts_r > PTS_RST);
  wire [EV_W-1:0] ev = {state_nxt == ST_ARMED && !in_armed,
                        accept,
                        state_nxt == ST_DONE && !in_done};

  twc_front u_front (
    .clk_i       (clk_i),
    .rst_i       (rst_i),
    .smp_valid_i (smp_valid_i),
    .smp_i       (smp_i),
    .ext_trig_i  (ext_trig_i),
    .src_i       (src_r),
    .falling_i   (fall_r),
    .level_i     (lvl_r),
    .hit_o       (hit),
    .dly_valid_o (dly_valid),
    .dly_data_o  (dly_data)
  );

  twc_ofs_mem u_ofs (
    .clk_i (clk_i),
    .we_i  (ofs_we),
    .wa_i  (ofs_wa),
    .wd_i  (ofs_wd),
    .ra_i  (sel_r),
    .rd_o  (ofs_rd)
  );

  // next state, commands take priority over sequencing
  always_comb begin
    state_nxt = state_r;
    if (clr_req) begin
      state_nxt = ST_IDLE;
    end else if (arm_req) begin
      state_nxt = ST_ARMING;
    end else if (frc_req) begin
      state_nxt = ST_TRIG;
    end else begin
      unique case (state_r)
        ST_IDLE:   state_nxt = ST_IDLE;
        ST_ARMING: state_nxt = hist_ok ? ST_ARMED : ST_ARMING;
        ST_ARMED:  state_nxt = hit ? ST_TRIG : ST_ARMED;
        ST_TRIG: begin
          if (seg_end) begin
            state_nxt = last_pt ? ST_DONE : ST_ARMED;
          end
        end
        ST_DONE:   state_nxt = ST_DONE;
        default:   state_nxt = ST_IDLE;
      endcase
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      state_r <= ST_IDLE;
      armed_o <= 1'b0;
      done_o  <= 1'b0;
    end else begin
      state_r <= state_nxt;
      armed_o <= (state_nxt == ST_ARMED);
      done_o  <= (state_nxt == ST_DONE);
    end
  end

  // configuration registers
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      src_r <= SRC_SOFT;
      fall_r <= 1'b0;
      beg_r <= '0;
      lvl_r <= '0;
      sel_r <= '0;
      len_r <= LEN_RST;
      pts_r <= PTS_RST;
    end else begin
      if (wr_cfg) {fall_r, src_r} <= {reg_wdata_i[CFG_FALL],
                                      reg_wdata_i[1:0]};
      if (wr_beg) beg_r <= reg_wdata_i;
      if (wr_lvl) lvl_r <= reg_wdata_i[SMP_W-1:0];
      if (wr_sel) sel_r <= reg_wdata_i[OFS_AW-1:0];
      if (wr_len) len_r <= reg_wdata_i[LEN_W-1:0];
      if (wr_pts) pts_r <= reg_wdata_i[PTS_W-1:0];
    end
  end

  // stream position counters
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      smp_cnt_r  <= '0;
      dly_idx_r  <= '0;
      hist_cnt_r <= '0;
    end else begin
      if (smp_valid_i) smp_cnt_r <= smp_cnt_r + 1'b1;
      if (dly_valid) dly_idx_r <= dly_idx_r + 1'b1;
      if (arm_req) begin
        hist_cnt_r <= '0;
      end else if (smp_valid_i && hist_cnt_r != HIST_CNT) begin
        hist_cnt_r <= hist_cnt_r + 1'b1;
      end
    end
  end

  // point acceptance and segment capture
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      start_r   <= '0;
      first_r   <= '0;
      acc_cnt_r <= '0;
      seg_cnt_r <= '0;
      cap_on_r  <= 1'b0;
    end else begin
      if (restart) acc_cnt_r <= '0;
      if (accept) begin
        start_r   <= trig_idx + beg_ext;
        acc_cnt_r <= acc_base + 1'b1;
        seg_cnt_r <= '0;
        cap_on_r  <= 1'b0;
        if (acc_base == '0) first_r <= trig_idx;
      end else if (seg_end || !in_trig) begin
        seg_cnt_r <= '0;
        cap_on_r  <= 1'b0;
      end else if (cap_go) begin
        seg_cnt_r <= seg_cnt_r + 1'b1;
        cap_on_r  <= 1'b1;
      end
    end
  end

  // progress counters
  always_ff @(posedge clk_i) begin
    if (rst_i || restart || clr_req) begin
      prog_r    <= '0;
      pt_prog_r <= '0;
      trg_cnt_r <= '0;
    end else begin
      if (cap_go) prog_r <= prog_r + 1'b1;
      if (seg_end) pt_prog_r <= pt_prog_r + 1'b1;
      if (hit && !in_idle) trg_cnt_r <= trg_cnt_r + 1'b1;
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      cap_valid_o <= 1'b0;
      cap_data_o  <= '0;
    end else begin
      cap_valid_o <= cap_go;
      if (cap_go) cap_data_o <= dly_data;
    end
  end

  // interrupt status, a new event wins over its clear
  assign irq_st_nxt = (irq_st_r & ~({EV_W{wr_iclr}}
                      & reg_wdata_i[EV_W-1:0])) | ev;

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      irq_st_r <= '0;
      irq_en_r <= '0;
      irq_o    <= 1'b0;
    end else begin
      irq_st_r <= irq_st_nxt;
      if (wr_ien) irq_en_r <= reg_wdata_i[EV_W-1:0];
      irq_o    <= |(irq_st_nxt & (wr_ien ? reg_wdata_i[EV_W-1:0]
                                          : irq_en_r));
    end
  end

  // read selection
  assign rd_mux =
    (reg_addr_i == OFS_CFG)    ? DAT_W'({fall_r, 2'h0, src_r}) :
    (reg_addr_i == OFS_BEGIN)  ? beg_r :
    (reg_addr_i == OFS_LENGTH) ? DAT_W'(len_r) :
    (reg_addr_i == OFS_POINTS) ? DAT_W'(pts_r) :
    (reg_addr_i == OFS_LEVEL)  ? DAT_W'(lvl_r) :
    (reg_addr_i == OFS_STATE)  ? DAT_W'({ofs_ok, in_done, in_armed,
                                         5'h00, st_code}) :
    (reg_addr_i == OFS_TOTAL)  ? DAT_W'(total) :
    (reg_addr_i == OFS_PROG)   ? DAT_W'(prog_r) :
    (reg_addr_i == OFS_PTPROG) ? DAT_W'(pt_prog_r) :
    (reg_addr_i == OFS_TRGCNT) ? trg_cnt_r :
    (reg_addr_i == OFS_PTSEL)  ? DAT_W'(sel_r) :
    (reg_addr_i == OFS_PTLO)   ? ofs_rd[DAT_W-1:0] :
    (reg_addr_i == OFS_PTHI)   ? ofs_rd[IDX_W-1:DAT_W] :
    (reg_addr_i == OFS_IRQ_ST) ? DAT_W'(irq_st_r) :
    (reg_addr_i == OFS_IRQ_EN) ? DAT_W'(irq_en_r) : '0;

  always_ff @(posedge clk_i) begin
    reg_rdata_o <= (rst_i || !reg_rd_i) ? '0 : rd_mux;
  end

  // checks
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (rst_i);

  armed_flag_a: assert property (armed_o == in_armed)
    else $error("armed flag disagrees with state");
  done_flag_a: assert property (done_o == in_done)
    else $error("done flag disagrees with state");
  clear_idle_a: assert property (clr_req |=> in_idle)
    else $error("clear did not reach idle");
  arm_path_a: assert property (arm_req && !beg_r[DAT_W-1]
    |=> in_armg ##1 (in_armed || $past(wr_ctrl)))
    else $error("arm did not reach armed");
  force_trig_a: assert property (frc_req |=> in_trig)
    else $error("force did not enter triggered");
  done_prog_a: assert property ($rose(in_done)
    |-> prog_r == total)
    else $error("sample progress short at done");
  done_pts_a: assert property ($rose(in_done)
    |-> pt_prog_r == pts_r && acc_cnt_r == pts_r)
    else $error("point progress short at done");
  seg_len_a: assert property (seg_end && !wr_ctrl
    |=> prog_r == TOT_W'(len_r) * TOT_W'(pt_prog_r))
    else $error("segment length wrong");
  arming_wait_a: assert property (in_armg && !hist_ok
    && !wr_ctrl |=> in_armg)
    else $error("arming left early");
  ofs_flag_a: assert property (reg_rd_i && !(pts_r > PTS_RST
    && in_done) && reg_addr_i == OFS_STATE |=> !reg_rdata_o[ST_OFSBIT])
    else $error("offset list flagged valid wrongly");

  done_seen_c: cover property ($rose(in_done) && pts_r > PTS_RST);
  rearm_c: cover property (in_trig ##1 in_armed);
  forced_c: cover property (in_idle && frc_req);
  irq_c: cover property ($rose(irq_o));
endmodule
